// ==== core/ext_bus_defs.svh ====
// Constants for the external memory bus strobe block
// Assumes inclusion by bare name from core files
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH

`define PHASES_PER_CYCLE    4'hc
`define ALE_PHASE_A         4'h0
`define ALE_PHASE_B         4'h6
`define FETCH_PHASE_A       4'h2
`define FETCH_PHASE_B       4'h8
`define FETCH_PHASE_LEN     4'h3
`define INT_CODE_LIMIT      16'h8000
`define QUIET_LATCH_BIT_POS 5
`define POWER_CONTROL_REGISTER_RESET          8'h00

`endif

// ==== core/ext_bus_pkg.sv ====
// Types for the external memory bus strobe block
// Assumes no other package
package ext_bus_pkg;

	typedef enum logic [1:0] {
		ACC_NONE,
		ACC_READ,
		ACC_WRITE
	} data_acc_t;

	typedef struct packed {
		logic       fetch_req;
		logic [15:0] pc;
		data_acc_t  data_acc;
		logic [15:0] data_addr;
		logic [7:0] wr_data;
		logic       wide_addr;
	} cpu_req_t;

	typedef struct packed {
		logic [7:0] p0_out;
		logic [7:0] p0_oe_n;
		logic       p0_pullup;
		logic [7:0] p2_out;
		logic       fetch_strobe_n;
		logic       latch_strobe;
		logic       rd_n;
		logic       wr_n;
	} bus_pins_t;

	typedef struct packed {
		logic [3:0] phase;
		logic       ext_fetch_sel;
		logic       sel_captured;
		logic [7:0] power_control_register;
		logic       in_data_acc;
		logic [7:0] rd_data;
		logic       rd_valid;
		bus_pins_t  pins;
	} state_t;

endpackage

// ==== core/ext_bus_strobes.sv ====
// External memory bus strobes, address ports and mode pins
// Assumes one oscillator-period clock and a CPU request bundle
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defs.svh"

module ext_bus_strobes (
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_n_i,
	input  wire ext_bus_pkg::cpu_req_t cpu_req_i,
	input  wire logic                 power_control_register_wr_i,
	input  wire logic [7:0]           power_control_register_wdata_i,
	input  wire logic                 idle_req_i,
	input  wire logic                 pdown_req_i,
	input  wire logic                 wake_int_i,
	input  wire logic                 flash_verify_i,
	input  wire logic                 flash_oe_n_i,
	input  wire logic                 external_fetch_select_i,
	input  wire logic                 oscillator_source_select_i,
	input  wire logic [7:0]           port_zero_i,
	output logic [7:0]                port_zero_o,
	output logic [7:0]                port_zero_oe_n_o,
	output logic                      port_zero_pullup_o,
	output logic [7:0]                port_two_o,
	output logic                      program_fetch_strobe_o,
	output logic                      address_latch_strobe_o,
	output logic                      ext_rd_n_o,
	output logic                      ext_wr_n_o,
	output logic [7:0]                power_control_o,
	output logic                      ext_fetch_latched_o,
	output logic [7:0]                rd_data_o,
	output logic                      rd_valid_o,
	output logic                      cpu_run_o,
	output logic                      osc_run_o,
	output logic                      use_pll_o,
	output logic                      low_freq_crystal_out_o,
	output logic                      low_freq_crystal_in_o
);

	ext_bus_pkg::state_t state_reg;
	ext_bus_pkg::state_t state_next;

	logic fetch_ext;
	logic data_ext;
	logic quiet;
	logic idle;
	logic pdown;
	logic ale_slot;
	logic fetch_slot;
	logic [15:0] addr;

	// ****************************************************
	// Phase helpers
	// ****************************************************
	function automatic logic in_window(input logic [3:0] ph, input logic [3:0] start,
		input logic [3:0] len);
		in_window = (ph >= start) && (ph < 4'(start + len));
	endfunction

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb begin
		state_next = state_reg;
		idle  = state_reg.power_control_register[0];
		pdown = state_reg.power_control_register[1];
		quiet = state_reg.power_control_register[`QUIET_LATCH_BIT_POS];
		fetch_ext = cpu_req_i.fetch_req &&
			(!state_reg.ext_fetch_sel || (cpu_req_i.pc >= `INT_CODE_LIMIT));
		data_ext = (cpu_req_i.data_acc != ext_bus_pkg::ACC_NONE);
		ale_slot = (state_reg.phase == `ALE_PHASE_A) || (state_reg.phase == `ALE_PHASE_B);
		fetch_slot = in_window(state_reg.phase, `FETCH_PHASE_A, `FETCH_PHASE_LEN) ||
			in_window(state_reg.phase, `FETCH_PHASE_B, `FETCH_PHASE_LEN);
		addr = state_reg.in_data_acc ? cpu_req_i.data_addr : cpu_req_i.pc;

		// Oscillator periods within one machine cycle
		if (!pdown) begin
			state_next.phase = (state_reg.phase == 4'(`PHASES_PER_CYCLE - 4'h1)) ?
				4'h0 : 4'(state_reg.phase + 4'h1);
		end
		if (state_reg.phase == 4'h0) begin
			state_next.in_data_acc = data_ext;
		end

		// Power control writes and wake-up
		if (power_control_register_wr_i) begin
			state_next.power_control_register = power_control_register_wdata_i;
		end
		if (idle_req_i) begin
			state_next.power_control_register[0] = 1'b1;
		end
		if (pdown_req_i) begin
			state_next.power_control_register[1] = 1'b1;
		end
		if (wake_int_i) begin
			state_next.power_control_register[1:0] = 2'b00;
		end

		// Fetch-select strap taken once after reset release
		if (!state_reg.sel_captured) begin
			state_next.ext_fetch_sel = external_fetch_select_i;
			state_next.sel_captured  = 1'b1;
		end

		// Program fetch strobe
		state_next.pins.fetch_strobe_n = !(fetch_ext && fetch_slot && !idle && !pdown &&
			!state_reg.in_data_acc);

		// Address latch strobe
		if (pdown) begin
			state_next.pins.latch_strobe = !quiet ? state_reg.pins.latch_strobe : 1'b0;
		end else if (idle) begin
			state_next.pins.latch_strobe = 1'b1;
		end else if (!quiet || !state_reg.ext_fetch_sel || fetch_ext ||
			state_reg.in_data_acc) begin
			state_next.pins.latch_strobe = ale_slot &&
				!(state_reg.in_data_acc && state_reg.phase == `ALE_PHASE_B);
		end else begin
			state_next.pins.latch_strobe = 1'b0;
		end

		// Port two high address and flash output enable
		state_next.pins.p2_out = (fetch_ext || state_reg.in_data_acc) ?
			addr[15:8] : 8'hff;
		if (flash_verify_i) begin
			state_next.pins.p2_out[7] = flash_oe_n_i;
		end

		// Port zero multiplexed address then data
		state_next.pins.p0_pullup = fetch_ext || state_reg.in_data_acc;
		state_next.pins.rd_n = 1'b1;
		state_next.pins.wr_n = 1'b1;
		state_next.rd_valid  = 1'b0;
		if (ale_slot && (fetch_ext || state_reg.in_data_acc)) begin
			state_next.pins.p0_out  = addr[7:0];
			state_next.pins.p0_oe_n = 8'h00;
		end else if (state_reg.in_data_acc && state_reg.phase > `ALE_PHASE_B) begin
			if (cpu_req_i.data_acc == ext_bus_pkg::ACC_WRITE) begin
				state_next.pins.p0_out  = cpu_req_i.wr_data;
				state_next.pins.p0_oe_n = 8'h00;
				state_next.pins.wr_n    = 1'b0;
			end else begin
				state_next.pins.p0_oe_n = 8'hff;
				state_next.pins.rd_n    = 1'b0;
				if (state_reg.phase == 4'(`PHASES_PER_CYCLE - 4'h1)) begin
					state_next.rd_data  = port_zero_i;
					state_next.rd_valid = 1'b1;
				end
			end
		end else begin
			state_next.pins.p0_oe_n = 8'hff;
		end
	end

	// ****************************************************
	// State register
	// ****************************************************
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= '0;
			state_reg.power_control_register <= `POWER_CONTROL_REGISTER_RESET;
			state_reg.pins.fetch_strobe_n <= 1'b1;
			state_reg.pins.p0_oe_n <= 8'hff;
			state_reg.pins.p2_out <= 8'hff;
			state_reg.pins.rd_n <= 1'b1;
			state_reg.pins.wr_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	assign port_zero_o            = state_reg.pins.p0_out;
	assign port_zero_oe_n_o       = state_reg.pins.p0_oe_n;
	assign port_zero_pullup_o     = state_reg.pins.p0_pullup;
	assign port_two_o             = state_reg.pins.p2_out;
	assign program_fetch_strobe_o = state_reg.pins.fetch_strobe_n;
	assign address_latch_strobe_o = state_reg.pins.latch_strobe;
	assign ext_rd_n_o             = state_reg.pins.rd_n;
	assign ext_wr_n_o             = state_reg.pins.wr_n;
	assign power_control_o        = state_reg.power_control_register;
	assign ext_fetch_latched_o    = state_reg.ext_fetch_sel;
	assign rd_data_o              = state_reg.rd_data;
	assign rd_valid_o             = state_reg.rd_valid;
	assign cpu_run_o              = !state_reg.power_control_register[0] && !state_reg.power_control_register[1];
	assign osc_run_o              = !state_reg.power_control_register[1];
	assign use_pll_o              = !oscillator_source_select_i;
	assign low_freq_crystal_out_o = 1'b0;
	assign low_freq_crystal_in_o  = 1'b0;

endmodule

`default_nettype wire

// ==== bench/ext_bus_strobes_props.sv ====
// Port assertions for the strobe block
// Assumes bind onto ext_bus_strobes
`timescale 1ns/1ps
`default_nettype none
module ext_bus_props (
	input wire logic                  sys_clk_i,
	input wire logic                  rst_n_i,
	input wire ext_bus_pkg::cpu_req_t cpu_req_i,
	input wire logic                  oscillator_source_select_i,
	input wire logic                  program_fetch_strobe_o,
	input wire logic                  address_latch_strobe_o,
	input wire logic                  ext_rd_n_o,
	input wire logic                  port_zero_pullup_o,
	input wire logic [7:0]            power_control_o,
	input wire logic                  ext_fetch_latched_o,
	input wire logic                  cpu_run_o,
	input wire logic                  use_pll_o,
	input wire logic                  low_freq_crystal_out_o,
	input wire logic                  low_freq_crystal_in_o
);
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!rst_n_i);
logic quiet_int;
logic idle_q;
logic down_q;
assign quiet_int = power_control_o[5] && ext_fetch_latched_o && cpu_run_o
	&& cpu_req_i.data_acc == ext_bus_pkg::ACC_NONE && cpu_req_i.pc < 16'h8000;
assign idle_q = power_control_o[5] && power_control_o[0];
assign down_q = power_control_o[5] && power_control_o[1];
latch_width_a: assert property ($rose(address_latch_strobe_o) && cpu_run_o |=>
	!address_latch_strobe_o || !cpu_run_o)
	else $error("latch pulse too wide");
fetch_width_a: assert property ($fell(program_fetch_strobe_o) |->
	##1 !program_fetch_strobe_o ##1 !program_fetch_strobe_o ##1 program_fetch_strobe_o)
	else $error("fetch pulse not three cycles");
quiet_low_a: assert property (quiet_int && $past(quiet_int) && $past(quiet_int, 2)
	|-> !address_latch_strobe_o) else $error("latch moved in quiet mode");
idle_high_a: assert property (idle_q && $past(idle_q, 2) |-> address_latch_strobe_o)
	else $error("latch not high in idle");
down_low_a: assert property (down_q && $past(down_q, 2) |-> !address_latch_strobe_o)
	else $error("latch not low in power-down");
ctl_reset_a: assert property ($past(!rst_n_i) |-> power_control_o == 8'h00)
	else $error("power control not cleared");
strap_hold_a: assert property ($past(rst_n_i) && $past(rst_n_i, 2) |-> $stable(ext_fetch_latched_o))
	else $error("strap changed after reset");
pullup_on_a: assert property (!ext_rd_n_o |-> port_zero_pullup_o)
	else $error("no pull-up during access");
halt_fetch_a: assert property (!cpu_run_o && $past(!cpu_run_o) |-> program_fetch_strobe_o)
	else $error("fetch strobe while halted");
pll_pick_a: assert property (use_pll_o == !oscillator_source_select_i)
	else $error("clock source wrong");
xtal_low_a: assert property (!use_pll_o |-> !low_freq_crystal_out_o && !low_freq_crystal_in_o)
	else $error("crystal pins not low");
endmodule
bind ext_bus_strobes ext_bus_props u_ext_bus_props (.*);
`default_nettype wire

// ==== bench/ext_mem_model.sv ====
// External memory behind an address latch
// Assumes bench resolves the shared low port
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	input wire logic       sys_clk_i,
	input wire logic       address_latch_strobe_i,
	input wire logic       program_fetch_strobe_i,
	input wire logic       ext_rd_n_i,
	input wire logic [7:0] port_zero_i,
	input wire logic [7:0] port_two_i,
	output logic           drive_o,
	output logic [7:0]     data_o
);
logic [7:0] addr_low_reg;
always_ff @(posedge sys_clk_i)
	if (address_latch_strobe_i) addr_low_reg <= port_zero_i;
assign drive_o = !program_fetch_strobe_i || !ext_rd_n_i;
assign data_o = addr_low_reg ^ port_two_i;
endmodule
`default_nettype wire

// ==== bench/test_ext_bus_strobes.sv ====
// Bench for the strobe block
// Assumes the memory model on the far side
`timescale 1ns/1ps
`default_nettype none
module test_ext_bus_strobes;
logic sys_clk, rst_n, pw, idle, pd, wake, fv, foe, strap, osc;
logic [7:0] wd, zo, zoe_n, two, ctl, rdd, mdat, zbus, two_seen;
logic pu, fs, ls, rdn, wrn, lat, rdv, run_o, orun, pll, lfo, lfi, mdrv;
ext_bus_pkg::cpu_req_t req;
int mismatches = 0, cmp_count = 0, na, nf;
assign zbus = ~zoe_n & zo | zoe_n & (mdrv ? mdat : 8'hff);
ext_bus_strobes u_ext_bus_strobes (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .cpu_req_i(req),
	.power_control_register_wr_i(pw), .power_control_register_wdata_i(wd), .idle_req_i(idle), .pdown_req_i(pd),
	.wake_int_i(wake), .flash_verify_i(fv), .flash_oe_n_i(foe),
	.external_fetch_select_i(strap), .oscillator_source_select_i(osc), .port_zero_i(zbus),
	.port_zero_o(zo), .port_zero_oe_n_o(zoe_n), .port_zero_pullup_o(pu), .port_two_o(two),
	.program_fetch_strobe_o(fs), .address_latch_strobe_o(ls), .ext_rd_n_o(rdn),
	.ext_wr_n_o(wrn), .power_control_o(ctl), .ext_fetch_latched_o(lat), .rd_data_o(rdd),
	.rd_valid_o(rdv), .cpu_run_o(run_o), .osc_run_o(orun), .use_pll_o(pll),
	.low_freq_crystal_out_o(lfo), .low_freq_crystal_in_o(lfi));
ext_mem_model u_ext_mem_model (.sys_clk_i(sys_clk), .address_latch_strobe_i(ls),
	.program_fetch_strobe_i(fs), .ext_rd_n_i(rdn), .port_zero_i(zbus), .port_two_i(two),
	.drive_o(mdrv), .data_o(mdat));
task automatic check(input logic [15:0] seen, exp);
	cmp_count++;
	if (seen !== exp) begin
		mismatches++;
		$display("Error at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
task automatic span(input int n);
	logic la, fa;
	la = ls;
	fa = fs;
	na = 0;
	nf = 0;
	repeat (n) begin
		@(negedge sys_clk);
		na += int'(ls && !la);
		nf += int'(!fs && fa);
		if (!fs) two_seen = two;
		la = ls;
		fa = fs;
	end
endtask
task automatic do_reset(input logic s);
	rst_n = 0;
	strap = s;
	repeat (16) @(negedge sys_clk);
	rst_n = 1;
	repeat (2) @(negedge sys_clk);
	strap = !s;
endtask
task automatic pulse(ref logic sig);
	sig = 1;
	@(negedge sys_clk);
	sig = 0;
endtask
task automatic close_out;
	$display("Compares %0d mismatches %0d", cmp_count, mismatches);
	if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
	else $display("TB: FAIL");
	$finish;
endtask
initial begin
	sys_clk = 0;
	forever #2 sys_clk = ~sys_clk;
end
initial begin
	#20000;
	mismatches++;
	close_out();
end
initial begin
	{req, pw, wd, idle, pd, wake, fv, foe} = '0;
	osc = 1;
	do_reset(0);
	check(ctl, 8'h00);
	check({lfo, lfi}, 2'b00);
	req.fetch_req = 1;
	req.pc = 16'h9a5c;
	req.wide_addr = 1;
	span(12);
	span(24);
	check(na, 4);
	check(nf, 4);
	check(two_seen, 8'h9a);
	check(mdat, 8'hc6);
	wd = 8'h20;
	pulse(pw);
	check(ctl, 8'h20);
	span(24);
	check(na, 4);
	$display("test external fetch done");
	req.data_acc = ext_bus_pkg::ACC_READ;
	req.data_addr = 16'h3c71;
	span(12);
	span(24);
	check(na, 2);
	check(nf, 0);
	check(rdd, 8'h4d);
	$display("test data read done");
	req.data_acc = ext_bus_pkg::ACC_NONE;
	req.pc = 16'h1234;
	do_reset(1);
	pulse(pw);
	span(12);
	span(24);
	check(na, 0);
	check(nf, 0);
	check(lat, 1'b1);
	span(9);
	req.pc = 16'h8001;
	span(12);
	span(24);
	check(na, 4);
	check(nf, 4);
	req.pc = 16'h1234;
	req.data_acc = ext_bus_pkg::ACC_WRITE;
	span(12);
	span(24);
	check(na, 2);
	$display("test internal fetch done");
	req.data_acc = ext_bus_pkg::ACC_NONE;
	pulse(idle);
	span(24);
	check(ls, 1'b1);
	check(run_o, 1'b0);
	check(nf, 0);
	pulse(wake);
	pulse(pd);
	span(24);
	check(ls, 1'b0);
	check(orun, 1'b0);
	pulse(wake);
	span(2);
	check(orun, 1'b1);
	osc = 0;
	fv = 1;
	span(3);
	check(pll, 1'b1);
	check(two[7], 1'b0);
	foe = 1;
	span(3);
	check(two[7], 1'b1);
	$display("test modes done");
	close_out();
end
endmodule
`default_nettype wire
